// ---- design/obtt_comparator.v ----
// one 16-bit comparator: equality and both magnitude relations
// assumes: operands come from logic on the same clock
`timescale 1ns/100ps
`default_nettype none

module obtt_comparator #(
  parameter W = 16
) (
  input  wire [W-1:0] value_i,
  input  wire [W-1:0] ref_i,
  output wire         eq_o,
  output wire         ge_o,
  output wire         le_o
);

  assign eq_o = (value_i == ref_i);
  assign ge_o = (value_i >= ref_i);
  assign le_o = (value_i <= ref_i);

endmodule // obtt_comparator

`default_nettype wire

// ---- design/obtt_defines.vh ----
// register map, field positions, reset values and mode codes of the trigger/trace unit
// assumes: included by the unit's design files by bare name
`ifndef OBTT_DEFINES_VH
`define OBTT_DEFINES_VH

`define OBTT_AW              4
`define OBTT_DW              8
`define OBTT_REG_CMPA_H      4'h0
`define OBTT_REG_CMPA_L      4'h1
`define OBTT_REG_CMPB_H      4'h2
`define OBTT_REG_CMPB_L      4'h3
`define OBTT_REG_TRACE_H     4'h4
`define OBTT_REG_TRACE_L     4'h5
`define OBTT_REG_CTRL        4'h6
`define OBTT_REG_TRIG        4'h7
`define OBTT_REG_STAT        4'h8
`define OBTT_REG_INT_STAT    4'h9
`define OBTT_REG_INT_MASK    4'hA

`define OBTT_CTRL_ARM        7
`define OBTT_CTRL_BRK        6
`define OBTT_CTRL_TAG        5
`define OBTT_CTRL_BEGIN      4
`define OBTT_CTRL_CMP_A_DIR_QUALIFY_EN      3
`define OBTT_CTRL_RWA        2
`define OBTT_CTRL_RWBEN      1
`define OBTT_CTRL_RWB        0
`define OBTT_CTRL_RST        8'h00
`define OBTT_TRIG_RST        8'h00
`define OBTT_MASK_RST        8'h00
`define OBTT_CMP_RST         16'h0000

`define OBTT_MODE_A_ONLY     3'h0
`define OBTT_MODE_A_OR_B     3'h1
`define OBTT_MODE_A_AND_BD   3'h2
`define OBTT_MODE_A_NOT_BD   3'h3
`define OBTT_MODE_INSIDE     3'h4
`define OBTT_MODE_OUTSIDE    3'h5
`define OBTT_MODE_STORE_DATA 3'h6
`define OBTT_MODE_B_ONLY     3'h7

`define OBTT_INT_MATCH       0
`define OBTT_INT_FULL        1
`define OBTT_INT_DONE        2

`define OBTT_DEPTH           8
`define OBTT_CNT_W           4
`define OBTT_ENTRY_W         16

`endif

// ---- design/obtt_top.v ----
// bus trigger and trace unit: comparators, trigger logic, registers, interrupt
// assumes: cpu bus, debug-controller flag and register port all run on clk_i
//
// Added by the designer: strobed register access and the register addresses.
`timescale 1ns/100ps
`default_nettype none

`include "obtt_defines.vh"

// Functional notes
// - eight-entry buffer of address or data
// - two 16-bit comparators, optional qualifiers
// - per-comparator bit ignores read/write direction
// - opcode tracking triggers only on execution
// - magnitude compare for inside/outside range
// - comparators off during debug-controller accesses
// - comparator A always sees address bus
// - comparator B sees address or data
// - write data when enabled and write
// - match breaks cpu or stores data
// - begin trace starts, end trace stops
// - configure before arming; read in order
// - count of valid entries, 1000 full
// - manual halt before full shifts one
// - registers and buffer reachable from host
// - registers also in cpu memory map; here reachable only through the host register port
module obtt_top #(
  parameter DEPTH = `OBTT_DEPTH,
  parameter CW    = `OBTT_CNT_W
) (
  input  wire                 clk_i,
  input  wire                 reset_n_i,
  input  wire                 ce_i,
  input  wire [`OBTT_AW-1:0]  reg_addr_i,
  input  wire [`OBTT_DW-1:0]  reg_wdata_i,
  input  wire                 reg_wr_i,
  input  wire                 reg_rd_i,
  output wire [`OBTT_DW-1:0]  reg_rdata_o,
  input  wire                 bdc_access_i,
  input  wire [15:0]          cpu_addr_i,
  input  wire                 cpu_valid_i,
  input  wire                 cpu_rw_i,
  input  wire [7:0]           cpu_wdata_i,
  input  wire [7:0]           cpu_rdata_i,
  input  wire                 cpu_exec_i,
  input  wire [15:0]          cpu_exec_addr_i,
  input  wire                 cpu_cof_i,
  input  wire [15:0]          cpu_cof_addr_i,
  output wire                 break_req_o,
  output wire                 irq_o
);

  reg  [15:0]             cmpa_q;
  reg  [15:0]             cmpb_q;
  reg  [7:0]              ctrl_q;
  reg  [7:0]              trig_q;
  reg  [2:0]              int_stat_q;
  reg  [2:0]              int_mask_q;
  reg                     tracing_q;
  reg                     break_q;
  reg                     irq_q;
  reg  [`OBTT_DW-1:0]     rdata_q;
  reg  [`OBTT_DW-1:0]     rdata_d;
  reg                     mode_match;

  // control fields and register strobes
  wire                    arm;
  wire                    tag;
  wire                    cmp_a_dir_qualify_en;
  wire                    cmp_a_dir_select;
  wire                    rwben;
  wire                    rwb;
  wire [2:0]              mode;
  wire                    wr_ctrl;
  wire                    wr_int_stat;
  wire                    wr_int_mask;
  wire                    arm_rise;
  wire                    halt_req;

  // comparator paths
  wire [15:0]             a_val;
  wire                    a_strobe;
  wire                    a_dir_ok;
  wire                    b_dir_ok;
  wire                    b_is_data;
  wire [7:0]              bdata;
  wire [15:0]             b_val;
  wire [15:0]             b_ref;
  wire                    a_eq;
  wire                    a_ge;
  wire                    b_eq;
  wire                    b_le;
  wire                    in_range;
  wire                    hit_a;
  wire                    hit_b;
  wire                    qual;

  // trace buffer
  wire                    store_mode;
  wire                    cof_take;
  wire                    push;
  wire [`OBTT_ENTRY_W-1:0] push_data;
  wire                    pop;
  wire [`OBTT_ENTRY_W-1:0] fifo_data;
  wire [CW-1:0]           fifo_count;
  wire                    fifo_full;
  wire [`OBTT_DW-1:0]     stat_word;

  // run sequencing and interrupt
  wire                    seq_hit;
  wire                    begin_hit;
  wire                    end_hit;
  wire                    full_rise;
  wire                    done_evt;
  reg                     full_q;
  wire [2:0]              events;
  wire [2:0]              int_clr;
  wire [2:0]              int_stat_d;
  wire                    irq_d;

  // control fields
  assign arm   = ctrl_q[`OBTT_CTRL_ARM];
  assign tag   = ctrl_q[`OBTT_CTRL_TAG];
  assign cmp_a_dir_qualify_en = ctrl_q[`OBTT_CTRL_CMP_A_DIR_QUALIFY_EN];
  assign cmp_a_dir_select   = ctrl_q[`OBTT_CTRL_RWA];
  assign rwben = ctrl_q[`OBTT_CTRL_RWBEN];
  assign rwb   = ctrl_q[`OBTT_CTRL_RWB];
  assign mode  = trig_q[2:0];

  assign wr_ctrl  = reg_wr_i & (reg_addr_i == `OBTT_REG_CTRL);
  assign wr_int_stat = reg_wr_i & (reg_addr_i == `OBTT_REG_INT_STAT);
  assign wr_int_mask = reg_wr_i & (reg_addr_i == `OBTT_REG_INT_MASK);
  assign arm_rise = wr_ctrl & reg_wdata_i[`OBTT_CTRL_ARM] & ~arm;
  // manual halt before full
  assign halt_req = wr_ctrl & ~reg_wdata_i[`OBTT_CTRL_ARM] & arm & ~fifo_full;

  // comparator A source: executed opcode address or bus address
  assign a_val    = tag ? cpu_exec_addr_i : cpu_addr_i;
  assign a_strobe = tag ? cpu_exec_i : cpu_valid_i;
  assign a_dir_ok = tag | ~cmp_a_dir_qualify_en | (cpu_rw_i == cmp_a_dir_select);
  assign b_dir_ok = tag | ~rwben | (cpu_rw_i == rwb);

  // comparator B source selected by mode
  assign b_is_data = (mode == `OBTT_MODE_A_AND_BD) |
                     (mode == `OBTT_MODE_A_NOT_BD) |
                     (mode == `OBTT_MODE_STORE_DATA);
  assign bdata     = (cmp_a_dir_qualify_en & ~cmp_a_dir_select) ? cpu_wdata_i : cpu_rdata_i;
  assign b_val     = b_is_data ? {8'h00, bdata} : a_val;
  assign b_ref     = b_is_data ? {8'h00, cmpb_q[7:0]} : cmpb_q;

  obtt_comparator #(
    .W       (16)
  ) u_cmp_a (
    .value_i (a_val),
    .ref_i   (cmpa_q),
    .eq_o    (a_eq),
    .ge_o    (a_ge),
    .le_o    ()
  );

  obtt_comparator #(
    .W       (16)
  ) u_cmp_b (
    .value_i (b_val),
    .ref_i   (b_ref),
    .eq_o    (b_eq),
    .ge_o    (),
    .le_o    (b_le)
  );

  assign hit_a = a_eq & a_dir_ok;
  assign hit_b = b_eq & b_dir_ok;
  assign in_range = a_ge & b_le;

  // trigger mode decode
  always @* begin
    case (mode)
      `OBTT_MODE_A_ONLY:     mode_match = hit_a;
      `OBTT_MODE_A_OR_B:     mode_match = hit_a | hit_b;
      `OBTT_MODE_A_AND_BD:   mode_match = hit_a & hit_b;
      `OBTT_MODE_A_NOT_BD:   mode_match = hit_a & ~hit_b;
      `OBTT_MODE_INSIDE:     mode_match = in_range & a_dir_ok;
      `OBTT_MODE_OUTSIDE:    mode_match = ~in_range & a_dir_ok;
      `OBTT_MODE_STORE_DATA: mode_match = hit_a;
      `OBTT_MODE_B_ONLY:     mode_match = hit_b;
      default:               mode_match = 1'b0;
    endcase
  end

  // comparators blind while the debug controller owns the bus
  assign qual = arm & a_strobe & ~bdc_access_i & mode_match;

  // what goes into the buffer
  assign store_mode = (mode == `OBTT_MODE_STORE_DATA);
  assign cof_take   = tracing_q & cpu_cof_i & ~bdc_access_i;
  assign push = ~ctrl_q[`OBTT_CTRL_BRK] & arm &
                (store_mode ? qual : cof_take);
  assign push_data = store_mode ? {8'h00, bdata} :
                     cpu_cof_addr_i;
  assign pop = reg_rd_i & (reg_addr_i == `OBTT_REG_TRACE_L);

  obtt_trace_fifo #(
    .W            (`OBTT_ENTRY_W),
    .DEPTH        (DEPTH),
    .CW           (CW)
  ) u_fifo (
    .clk_i        (clk_i),
    .ce_i         (ce_i),
    .reset_n_i    (reset_n_i),
    .clear_i      (arm_rise),
    .push_i       (push),
    .data_i       (push_data),
    .pop_i        (pop),
    .halt_shift_i (halt_req),
    .data_o       (fifo_data),
    .count_o      (fifo_count),
    .full_o       (fifo_full)
  );

  assign full_rise = fifo_full & ~full_q;

  // trace sequencing events; break and data store leave the run alone
  assign seq_hit   = qual & ~ctrl_q[`OBTT_CTRL_BRK] & ~store_mode;
  assign begin_hit = seq_hit & ctrl_q[`OBTT_CTRL_BEGIN];
  assign end_hit   = seq_hit & ~ctrl_q[`OBTT_CTRL_BEGIN];
  // run over: buffer filled, or end-type match while storing
  assign done_evt  = full_rise | (end_hit & tracing_q);

  // interrupt events, set beats clear
  assign events[`OBTT_INT_MATCH] = qual;
  assign events[`OBTT_INT_FULL]  = full_rise;
  assign events[`OBTT_INT_DONE]  = done_evt;
  assign int_clr    = wr_int_stat ? reg_wdata_i[2:0] : 3'h0;
  assign int_stat_d = (int_stat_q & ~int_clr) | events;
  assign irq_d      = |(int_stat_d & int_mask_q);

  // comparator and trigger mode registers
  always @(posedge clk_i) begin
    if (!reset_n_i) begin
      cmpa_q <= `OBTT_CMP_RST;
      cmpb_q <= `OBTT_CMP_RST;
      trig_q <= `OBTT_TRIG_RST;
    end else if (ce_i && reg_wr_i) begin
      case (reg_addr_i)
        `OBTT_REG_CMPA_H: cmpa_q[15:8] <= reg_wdata_i;
        `OBTT_REG_CMPA_L: cmpa_q[7:0]  <= reg_wdata_i;
        `OBTT_REG_CMPB_H: cmpb_q[15:8] <= reg_wdata_i;
        `OBTT_REG_CMPB_L: cmpb_q[7:0]  <= reg_wdata_i;
        `OBTT_REG_TRIG:   trig_q       <= reg_wdata_i;
        default: ;
      endcase
    end
  end

  // interrupt status, mask and level output
  always @(posedge clk_i) begin
    if (!reset_n_i) begin
      int_stat_q <= 3'h0;
      int_mask_q <= 3'h0;
      irq_q      <= 1'b0;
      full_q     <= 1'b0;
    end else if (ce_i) begin
      full_q     <= fifo_full;
      int_stat_q <= int_stat_d;
      irq_q      <= irq_d;
      if (wr_int_mask) begin
        int_mask_q <= reg_wdata_i[2:0];
      end
    end
  end

  // breakpoint request, one pulse per qualified match
  always @(posedge clk_i) begin
    if (!reset_n_i) begin
      break_q <= 1'b0;
    end else if (ce_i) begin
      break_q <= qual & ctrl_q[`OBTT_CTRL_BRK];
    end
  end

  // control register and trace run sequencing
  always @(posedge clk_i) begin
    if (!reset_n_i) begin
      ctrl_q    <= `OBTT_CTRL_RST;
      tracing_q <= 1'b0;
    end else if (ce_i) begin
      if (wr_ctrl) begin
        ctrl_q <= reg_wdata_i;
        if (arm_rise)
          tracing_q <= ~reg_wdata_i[`OBTT_CTRL_BEGIN];
        else if (!reg_wdata_i[`OBTT_CTRL_ARM])
          tracing_q <= 1'b0;
      end else if (arm) begin
        if (begin_hit)
          tracing_q <= 1'b1;
        if (end_hit) begin
          tracing_q              <= 1'b0;
          ctrl_q[`OBTT_CTRL_ARM] <= 1'b0;
        end
        if (fifo_full) begin
          tracing_q              <= 1'b0;
          ctrl_q[`OBTT_CTRL_ARM] <= 1'b0;
        end
      end
    end
  end

  // status word: armed, storing, full, spare, entry count
  assign stat_word = {arm, tracing_q, fifo_full, 1'b0, fifo_count};

  // read mux
  always @* begin
    rdata_d = 8'h00;
    case (reg_addr_i)
      `OBTT_REG_CMPA_H:   rdata_d = cmpa_q[15:8];
      `OBTT_REG_CMPA_L:   rdata_d = cmpa_q[7:0];
      `OBTT_REG_CMPB_H:   rdata_d = cmpb_q[15:8];
      `OBTT_REG_CMPB_L:   rdata_d = cmpb_q[7:0];
      `OBTT_REG_TRACE_H:  rdata_d = fifo_data[15:8];
      `OBTT_REG_TRACE_L:  rdata_d = fifo_data[7:0];
      `OBTT_REG_CTRL:     rdata_d = ctrl_q;
      `OBTT_REG_TRIG:     rdata_d = {5'h00, trig_q[2:0]};
      `OBTT_REG_STAT:     rdata_d = stat_word;
      `OBTT_REG_INT_STAT: rdata_d = {5'h00, int_stat_q};
      `OBTT_REG_INT_MASK: rdata_d = {5'h00, int_mask_q};
      default:            rdata_d = 8'h00;
    endcase
  end

  // read answer stands one cycle, then zero
  always @(posedge clk_i) begin
    if (!reset_n_i) begin
      rdata_q <= 8'h00;
    end else if (ce_i) begin
      rdata_q <= reg_rd_i ? rdata_d : 8'h00;
    end
  end

  assign reg_rdata_o = rdata_q;
  assign break_req_o = break_q;
  assign irq_o       = irq_q;

endmodule // obtt_top

`default_nettype wire

// ---- design/obtt_trace_fifo.v ----
// eight-entry trace buffer: shift register, newest at index 0
// assumes: push, pop, clear and halt shift come from logic on the same clock
`timescale 1ns/100ps
`default_nettype none

module obtt_trace_fifo #(
  parameter W     = 16,
  parameter DEPTH = 8,
  parameter CW    = 4
) (
  input  wire          clk_i,
  input  wire          ce_i,
  input  wire          reset_n_i,
  input  wire          clear_i,
  input  wire          push_i,
  input  wire [W-1:0]  data_i,
  input  wire          pop_i,
  input  wire          halt_shift_i,
  output wire [W-1:0]  data_o,
  output wire [CW-1:0] count_o,
  output wire          full_o
);

  reg  [W-1:0]  mem_q [0:DEPTH-1];
  reg  [CW-1:0] count_q;
  reg           offset_q;
  wire          full;
  wire          do_push;
  wire          do_pop;
  wire [CW-1:0] rd_idx;
  integer       i;

  assign full    = (count_q == DEPTH[CW-1:0]);
  assign do_push = push_i & ~full;
  assign do_pop  = pop_i & (count_q != {CW{1'b0}});
  // oldest entry, one further up after a halt shift
  assign rd_idx  = count_q - {{(CW-1){1'b0}}, ~offset_q};
  assign data_o  = (count_q == {CW{1'b0}}) ? {W{1'b0}} : mem_q[rd_idx[CW-2:0]];
  assign count_o = count_q;
  assign full_o  = full;

  always @(posedge clk_i) begin
    if (!reset_n_i) begin
      count_q  <= {CW{1'b0}};
      offset_q <= 1'b0;
      for (i = 0; i < DEPTH; i = i + 1)
        mem_q[i] <= {W{1'b0}};
    end else if (ce_i) begin
      if (clear_i) begin
        count_q  <= {CW{1'b0}};
        offset_q <= 1'b0;
      end else begin
        if (do_push || (halt_shift_i && !full)) begin
          for (i = DEPTH - 1; i > 0; i = i - 1)
            mem_q[i] <= mem_q[i-1];
          mem_q[0] <= do_push ? data_i : {W{1'b0}};
        end
        if (halt_shift_i && !full)
          offset_q <= 1'b1;
        if (do_push && !do_pop)
          count_q <= count_q + {{(CW-1){1'b0}}, 1'b1};
        else if (do_pop && !do_push)
          count_q <= count_q - {{(CW-1){1'b0}}, 1'b1};
      end
    end
  end

endmodule // obtt_trace_fifo

`default_nettype wire

// ---- verification/obtt_host_model.sv ----
// development host model: register reads and writes over the plain port
// assumes: strobes one cycle, read data in the cycle after the strobe
`timescale 1ns/100ps
`default_nettype none
module obtt_host_model (
  input  wire logic       clk_i,
  input  wire logic [7:0] reg_rdata_i,
  output logic      [3:0] reg_addr_o,
  output logic      [7:0] reg_wdata_o,
  output logic            reg_wr_o,
  output logic            reg_rd_o
);
  initial begin
    reg_addr_o = 4'h0;
    reg_wdata_o = 8'h00;
    reg_wr_o = 1'b0;
    reg_rd_o = 1'b0;
  end
  task wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge clk_i);
    reg_addr_o <= a;
    reg_wdata_o <= d;
    reg_wr_o <= 1'b1;
    @(posedge clk_i);
    reg_wr_o <= 1'b0;
  endtask
  task rd(input logic [3:0] a, output logic [7:0] d);
    @(posedge clk_i);
    reg_addr_o <= a;
    reg_rd_o <= 1'b1;
    @(posedge clk_i);
    reg_rd_o <= 1'b0;
    #1 d = reg_rdata_i;
  endtask
endmodule // obtt_host_model
`default_nettype wire

// ---- verification/obtt_top_checker.sv ----
// port-level assertions for the trigger/trace unit
// assumes: single clock, ce_i held high by the bench
`timescale 1ns/100ps
`default_nettype none
`include "obtt_defines.vh"
module obtt_top_checker #(
  parameter DEPTH = 8,
  parameter CW    = 4
) (
  input wire logic       clk_i,
  input wire logic       reset_n_i,
  input wire logic [3:0] reg_addr_i,
  input wire logic       reg_rd_i,
  input wire logic [7:0] reg_rdata_o,
  input wire logic       bdc_access_i,
  input wire logic       cpu_valid_i,
  input wire logic       cpu_exec_i,
  input wire logic       break_req_o,
  input wire logic       irq_o
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!reset_n_i);
  wire stat_rd = reg_rd_i && reg_addr_i == `OBTT_REG_STAT;
  wire trig_rd = reg_rd_i && reg_addr_i == `OBTT_REG_TRIG;
  a_rdata_idle: assert property (!$past(reg_rd_i) |-> reg_rdata_o == 8'h00)
    else $error("read data not zero outside read answer");
  a_unmapped_zero: assert property ($past(reg_rd_i) && $past(reg_addr_i) > 4'hA
    |-> reg_rdata_o == 8'h00) else $error("unmapped read not zero");
  a_stat_count: assert property ($past(stat_rd) |-> reg_rdata_o[3:0] <= DEPTH)
    else $error("entry count above depth");
  a_stat_full: assert property ($past(stat_rd) |-> reg_rdata_o[5] == (reg_rdata_o[3:0] == 4'h8))
    else $error("full flag disagrees with count");
  a_full_disarm: assert property ($past(stat_rd) && reg_rdata_o[5] |-> !reg_rdata_o[7])
    else $error("still armed while full");
  a_trig_upper: assert property ($past(trig_rd) |-> reg_rdata_o[7:3] == 5'h00)
    else $error("trigger mode upper bits not zero");
  a_break_cause: assert property (break_req_o |-> $past(cpu_valid_i || cpu_exec_i))
    else $error("break without bus cycle");
  a_break_blind: assert property ($past(bdc_access_i) |-> !break_req_o)
    else $error("break during debug access");
  c_break: cover property (break_req_o);
  c_irq: cover property (irq_o);
  c_full: cover property ($past(stat_rd) && reg_rdata_o[5]);
endmodule // obtt_top_checker
bind obtt_top obtt_top_checker #(.DEPTH(DEPTH), .CW(CW)) u_chk (
  .clk_i(clk_i), .reset_n_i(reset_n_i), .reg_addr_i(reg_addr_i), .reg_rd_i(reg_rd_i),
  .reg_rdata_o(reg_rdata_o), .bdc_access_i(bdc_access_i), .cpu_valid_i(cpu_valid_i),
  .cpu_exec_i(cpu_exec_i), .break_req_o(break_req_o), .irq_o(irq_o));
`default_nettype wire

// ---- verification/obtt_top_tb.sv ----
// self-checking bench for the trigger/trace unit
// assumes: host model drives registers, bench drives the cpu bus
`timescale 1ns/100ps
`default_nettype none
`include "obtt_defines.vh"
module obtt_top_tb;
  logic        clk_i = 1'b0;
  logic        reset_n_i = 1'b0;
  logic        bdc_access_i = 1'b0;
  logic        cpu_valid_i = 1'b0;
  logic        cpu_rw_i = 1'b1;
  logic        cpu_exec_i = 1'b0;
  logic        cpu_cof_i = 1'b0;
  logic [15:0] cpu_addr_i = 16'h0000;
  wire  [3:0]  reg_addr;
  wire  [7:0]  reg_wdata;
  wire  [7:0]  reg_rdata;
  wire         reg_wr;
  wire         reg_rd;
  wire         break_req;
  wire         irq;
  int          n_errors = 0;
  int          checks_done = 0;
  logic [7:0]  b;
  logic [7:0]  h;
  always #10 clk_i = ~clk_i;
  obtt_host_model host (.clk_i(clk_i), .reg_rdata_i(reg_rdata), .reg_addr_o(reg_addr),
    .reg_wdata_o(reg_wdata), .reg_wr_o(reg_wr), .reg_rd_o(reg_rd));
  obtt_top DUT (.clk_i(clk_i), .reset_n_i(reset_n_i), .ce_i(1'b1), .reg_addr_i(reg_addr),
    .reg_wdata_i(reg_wdata), .reg_wr_i(reg_wr), .reg_rd_i(reg_rd), .reg_rdata_o(reg_rdata),
    .bdc_access_i(bdc_access_i), .cpu_addr_i(cpu_addr_i), .cpu_valid_i(cpu_valid_i),
    .cpu_rw_i(cpu_rw_i), .cpu_wdata_i(8'h5A), .cpu_rdata_i(8'hA5), .cpu_exec_i(cpu_exec_i),
    .cpu_exec_addr_i(cpu_addr_i), .cpu_cof_i(cpu_cof_i), .cpu_cof_addr_i(cpu_addr_i),
    .break_req_o(break_req), .irq_o(irq));
  task chk(input logic [15:0] seen, input logic [15:0] exp);
    checks_done++;
    if (seen !== exp) begin
      n_errors++;
      $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task rdchk(input logic [3:0] a, input logic [7:0] exp);
    host.rd(a, b);
    chk({8'h00, b}, {8'h00, exp});
  endtask
  task ent(input logic [15:0] exp);
    host.rd(`OBTT_REG_TRACE_H, h);
    host.rd(`OBTT_REG_TRACE_L, b);
    chk({h, b}, exp);
  endtask
  task cpu(input logic v, input logic ex, input logic cf, input logic rw, input logic [15:0] a);
    @(posedge clk_i);
    cpu_valid_i <= v;
    cpu_exec_i <= ex;
    cpu_cof_i <= cf;
    cpu_rw_i <= rw;
    cpu_addr_i <= a;
    @(posedge clk_i);
    cpu_valid_i <= 1'b0;
    cpu_exec_i <= 1'b0;
    cpu_cof_i <= 1'b0;
    #1;
  endtask
  task t_regs;
    rdchk(`OBTT_REG_CTRL, `OBTT_CTRL_RST);
    rdchk(`OBTT_REG_STAT, 8'h00);
    host.wr(`OBTT_REG_CMPA_H, 8'h12);
    host.wr(`OBTT_REG_CMPA_L, 8'h34);
    rdchk(`OBTT_REG_CMPA_H, 8'h12);
    rdchk(`OBTT_REG_CMPA_L, 8'h34);
    host.wr(`OBTT_REG_TRIG, 8'hFF);
    rdchk(`OBTT_REG_TRIG, 8'h07);
    rdchk(4'hF, 8'h00);
    host.wr(`OBTT_REG_TRIG, 8'h00);
    $display("t_regs done");
  endtask
  task t_break;
    host.wr(`OBTT_REG_INT_MASK, 8'h01);
    host.wr(`OBTT_REG_CTRL, 8'hC0);
    cpu(1'b1, 1'b0, 1'b0, 1'b1, 16'h1234);
    chk({15'h0000, break_req}, 16'h0001);
    @(posedge clk_i);
    #1 chk({15'h0000, irq}, 16'h0001);
    host.wr(`OBTT_REG_CTRL, 8'hC0);
    @(posedge clk_i);
    bdc_access_i <= 1'b1;
    cpu(1'b1, 1'b0, 1'b0, 1'b1, 16'h1234);
    chk({15'h0000, break_req}, 16'h0000);
    @(posedge clk_i);
    bdc_access_i <= 1'b0;
    host.wr(`OBTT_REG_INT_STAT, 8'h07);
    repeat (2) @(posedge clk_i);
    #1 chk({15'h0000, irq}, 16'h0000);
    host.wr(`OBTT_REG_CTRL, 8'hE0);
    cpu(1'b1, 1'b0, 1'b0, 1'b1, 16'h1234);
    chk({15'h0000, break_req}, 16'h0000);
    cpu(1'b0, 1'b1, 1'b0, 1'b1, 16'h1234);
    chk({15'h0000, break_req}, 16'h0001);
    host.wr(`OBTT_REG_CTRL, 8'hCC);
    cpu(1'b1, 1'b0, 1'b0, 1'b0, 16'h1234);
    chk({15'h0000, break_req}, 16'h0000);
    host.wr(`OBTT_REG_CTRL, 8'hC4);
    cpu(1'b1, 1'b0, 1'b0, 1'b0, 16'h1234);
    chk({15'h0000, break_req}, 16'h0001);
    host.wr(`OBTT_REG_CMPB_H, 8'h12);
    host.wr(`OBTT_REG_CMPB_L, 8'h40);
    for (int m = 4; m < 6; m++) begin
      host.wr(`OBTT_REG_TRIG, m[7:0]);
      for (int j = 0; j < 2; j++) begin
        host.wr(`OBTT_REG_CTRL, 8'hC0);
        cpu(1'b1, 1'b0, 1'b0, 1'b1, (j == 0) ? 16'h1238 : 16'h1300);
        chk({15'h0000, break_req}, {15'h0000, (j == 0) ^ (m == 5)});
      end
    end
    $display("t_break done");
  endtask
  task t_data;
    host.wr(`OBTT_REG_TRIG, {5'h00, `OBTT_MODE_STORE_DATA});
    for (int j = 0; j < 2; j++) begin
      host.wr(`OBTT_REG_CTRL, 8'h00);
      host.wr(`OBTT_REG_CTRL, (j == 0) ? 8'h88 : 8'h80);
      cpu(1'b1, 1'b0, 1'b0, j[0], 16'h1234);
      ent((j == 0) ? 16'h005A : 16'h00A5);
    end
    $display("t_data done");
  endtask
  task t_trace(input int n);
    int k;
    k = (n > 8) ? 8 : n;
    host.wr(`OBTT_REG_TRIG, 8'h00);
    host.wr(`OBTT_REG_INT_STAT, 8'h07);
    host.wr(`OBTT_REG_CTRL, 8'h00);
    host.wr(`OBTT_REG_CTRL, 8'h80);
    for (int i = 0; i < n; i++) cpu(1'b0, 1'b0, 1'b1, 1'b1, 16'hA000 + i[15:0]);
    if (n < 8) host.wr(`OBTT_REG_CTRL, 8'h00);
    host.rd(`OBTT_REG_STAT, b);
    chk({8'h00, b & 8'h2F}, (n > 7) ? 16'h0028 : k[15:0]);
    rdchk(`OBTT_REG_INT_STAT, (n > 7) ? 8'h06 : 8'h00);
    for (int i = 0; i < k; i++) ent(16'hA000 + i[15:0]);
    $display("t_trace %0d done", n);
  endtask
  task t_end;
    host.wr(`OBTT_REG_INT_STAT, 8'h07);
    host.wr(`OBTT_REG_CTRL, 8'h00);
    host.wr(`OBTT_REG_CTRL, 8'h80);
    cpu(1'b1, 1'b0, 1'b0, 1'b1, 16'h1234);
    cpu(1'b0, 1'b0, 1'b1, 1'b1, 16'hA100);
    rdchk(`OBTT_REG_STAT, 8'h00);
    rdchk(`OBTT_REG_INT_STAT, 8'h05);
    host.wr(`OBTT_REG_CTRL, 8'h90);
    cpu(1'b0, 1'b0, 1'b1, 1'b1, 16'hA101);
    cpu(1'b1, 1'b0, 1'b0, 1'b1, 16'h1234);
    cpu(1'b0, 1'b0, 1'b1, 1'b1, 16'hA102);
    rdchk(`OBTT_REG_STAT, 8'hC1);
    ent(16'hA102);
    $display("t_end done");
  endtask
  task summarize;
    $display("checks=%0d errors=%0d", checks_done, n_errors);
    if (n_errors == 0 && checks_done > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  initial begin
    repeat (20000) @(posedge clk_i);
    n_errors++;
    summarize;
  end
  initial begin
    repeat (2) @(posedge clk_i);
    reset_n_i <= 1'b1;
    t_regs;
    t_break;
    t_data;
    t_trace(9);
    t_trace(3);
    t_end;
    summarize;
  end
endmodule // obtt_top_tb
`default_nettype wire
